//--- rtl/swm_ctl.v
/*
  Wake line mode control register for external lines 4 to 7, with
  per-line detectors, sticky event status and a level interrupt.
  Assumes a plain register port synchronous to clk_in and pins
  already synchronous to clk_in.
*/
`timescale 1ns/10ps
`include "swm_regs.vh"
// Behaviour
// - Mode field: 000 low, 001 high, 010 fall, 011 rise, 100 both
// - Enable bit gates each line as a standby release source
// - Reset: mode 010, seen 00, enable 0, spare bit 0
// - Top bit of each byte reads zero; spare bit carries no meaning
// - Seen field meaningful only in both-edge mode
// - Clearing a line's request also clears its seen field
module swm_ctl (
  // Clock and reset
  input wire clk_in,
  input wire resetn_in,
  // Register port
  input wire [3:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rdata_out,
  // External wake pins, lines 4 to 7
  input wire ext_wake_line4_in,
  input wire ext_wake_line5_in,
  input wire ext_wake_line6_in,
  input wire ext_wake_line7_in,
  // Pending request clear from the clear register, one bit per line
  input wire [3:0] wake_request_clear_in,
  // Results
  output reg [3:0] wake_req_out,
  output reg irq_out
);

  reg [2:0] mode_q [0:3];
  reg [3:0] enable_q;
  reg [3:0] status_q;
  reg [3:0] irq_en_q;
  reg [3:0] clr_q;
  wire [3:0] req;
  wire [1:0] seen [0:3];
  wire [3:0] pins = {ext_wake_line7_in, ext_wake_line6_in,
                     ext_wake_line5_in, ext_wake_line4_in};
  wire [31:0] mode_word;
  integer i;

  // Pack one line's byte: top bit zero, spare bit zero
  function [7:0] pack_line;
    input [2:0] mode;
    input [1:0] seen_v;
    input en;
    begin
      pack_line = {1'b0, mode, seen_v, `SWM_SPARE_RST, en};
    end
  endfunction

  // Per-line detectors
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gl
      swm_line u_line (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .mode_in(mode_q[g]),
        .enable_in(enable_q[g]),
        .clear_in(clr_q[g]),
        .pin_in(pins[g]),
        .req_out(req[g]),
        .seen_out(seen[g])
      );
    end
  endgenerate

  assign mode_word = {pack_line(mode_q[3], seen[3], enable_q[3]),
                      pack_line(mode_q[2], seen[2], enable_q[2]),
                      pack_line(mode_q[1], seen[1], enable_q[1]),
                      pack_line(mode_q[0], seen[0], enable_q[0])};

  // Register writes, status and outputs
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      for (i = 0; i < 4; i = i + 1) begin
        mode_q[i] <= `SWM_MODE_RST;
      end
      enable_q <= 4'h0;
      status_q <= 4'h0;
      irq_en_q <= 4'h0;
      clr_q <= 4'h0;
      rdata_out <= 32'h0;
      wake_req_out <= 4'h0;
      irq_out <= 1'b0;
    end else begin
      clr_q <= wake_request_clear_in;
      if (wr_in && addr_in == `SWM_OFS_MODE_CTL) begin
        // Ordering of mode and enable writes is software's duty
        for (i = 0; i < 4; i = i + 1) begin
          mode_q[i] <= wdata_in[i*8+`SWM_MODE_LSB +: 3];
          enable_q[i] <= wdata_in[i*8+`SWM_ENABLE_BIT];
        end
      end
      if (wr_in && addr_in == `SWM_OFS_IRQ_EN) begin
        irq_en_q <= wdata_in[3:0];
      end
      // Sticky status: new request wins over a write-one clear
      if (wr_in && addr_in == `SWM_OFS_CLEAR) begin
        status_q <= (status_q & ~wdata_in[3:0]) | req;
      end else begin
        status_q <= status_q | req;
      end
      wake_req_out <= req;
      irq_out <= |(status_q & irq_en_q);
      // Read data valid only in the cycle after the strobe
      if (rd_in) begin
        case (addr_in)
          `SWM_OFS_MODE_CTL: rdata_out <= mode_word;
          `SWM_OFS_STATUS: rdata_out <= {28'h0, status_q};
          `SWM_OFS_IRQ_EN: rdata_out <= {28'h0, irq_en_q};
          default: rdata_out <= 32'h0;
        endcase
      end else begin
        rdata_out <= 32'h0;
      end
    end
  end

endmodule // swm_ctl

//--- rtl/swm_line.v
/*
  One wake line: detects the selected level or edge, raises a
  standby release request, records the edge in both-edge mode.
  Assumes the pin is synchronous to clk_in and software obeys the
  mode-before-enable ordering.
*/
`timescale 1ns/10ps
`include "swm_regs.vh"
module swm_line (
  // Clock and reset
  input wire clk_in,
  input wire resetn_in,
  // Configuration
  input wire [2:0] mode_in,
  input wire enable_in,
  input wire clear_in,
  // Pin
  input wire pin_in,
  // Results
  output reg req_out,
  output reg [1:0] seen_out
);

  reg pin_q;
  reg hit;
  wire rise = pin_in & ~pin_q;
  wire fall = ~pin_in & pin_q;

  // Match logic for the selected mode
  always @* begin
    case (mode_in)
      `SWM_MODE_LOW: hit = ~pin_in;
      `SWM_MODE_HIGH: hit = pin_in;
      `SWM_MODE_FALL: hit = fall;
      `SWM_MODE_RISE: hit = rise;
      `SWM_MODE_BOTH: hit = rise | fall;
      default: hit = 1'b0; // Forbidden codes never wake
    endcase
  end

  // Request is a level that follows the match; edge record is sticky
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      pin_q <= 1'b0;
      req_out <= 1'b0;
      seen_out <= `SWM_SEEN_NONE;
    end else begin
      pin_q <= pin_in;
      req_out <= enable_in & hit;
      if (enable_in && mode_in == `SWM_MODE_BOTH && (rise | fall)) begin
        // Set wins over a clear in the same cycle
        seen_out <= seen_out | {fall, rise};
      end else if (clear_in) begin
        seen_out <= `SWM_SEEN_NONE;
      end
    end
  end

endmodule // swm_line

//--- rtl/swm_regs.vh
/*
  Constants for the wake line mode control slice (lines 4 to 7):
  register offsets, field positions, reset values and mode codes.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SWM_REGS_VH
`define SWM_REGS_VH

// Register offsets (byte addresses on the plain port)
`define SWM_OFS_MODE_CTL 4'h0
`define SWM_OFS_STATUS 4'h4
`define SWM_OFS_CLEAR 4'h8
`define SWM_OFS_IRQ_EN 4'hc

// Field positions within each line byte
`define SWM_ENABLE_BIT 0
`define SWM_SPARE_BIT 1
`define SWM_SEEN_LSB 2
`define SWM_MODE_LSB 4
`define SWM_TOP_BIT 7

// Detection mode codes
`define SWM_MODE_LOW 3'h0
`define SWM_MODE_HIGH 3'h1
`define SWM_MODE_FALL 3'h2
`define SWM_MODE_RISE 3'h3
`define SWM_MODE_BOTH 3'h4

// Recorded edge codes
`define SWM_SEEN_NONE 2'h0
`define SWM_SEEN_RISE 2'h1
`define SWM_SEEN_FALL 2'h2

// Reset values
`define SWM_MODE_RST 3'h2
`define SWM_SPARE_RST 1'b0

`endif

//--- sim/swm_ctl_props.sv
/* Port checker for swm_ctl; assumes one clock and sync reset. */
`timescale 1ns/10ps
module swm_ctl_props (
  // Clock and reset
  input wire clk_in,
  input wire resetn_in,
  // Register port
  input wire [3:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [31:0] rdata_out,
  // Pins and results
  input wire ext_wake_line4_in,
  input wire ext_wake_line5_in,
  input wire ext_wake_line6_in,
  input wire ext_wake_line7_in,
  input wire [3:0] wake_req_out,
  input wire irq_out
);
  // Pins as one vector
  wire [3:0] pins = {ext_wake_line7_in, ext_wake_line6_in,
    ext_wake_line5_in, ext_wake_line4_in};
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  property p_rst; disable iff (1'b0) !resetn_in |=> !wake_req_out && !irq_out; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_mask; $past(rd_in) && $past(addr_in) == 4'h0 |-> !(rdata_out & 32'h82828282); endproperty
  a_mask: assert property (p_mask) else $error("mask");
  property p_idle; !$past(rd_in) |-> rdata_out == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_unmap; rd_in && (addr_in[1:0] != 2'h0 || addr_in == 4'h8) |=> !rdata_out; endproperty
  a_unmap: assert property (p_unmap) else $error("unmap");
  property p_stat; $past(rd_in) && $past(addr_in) == 4'h4 |-> !rdata_out[31:4]; endproperty
  a_stat: assert property (p_stat) else $error("stat");
  // No pin change and no write: requests cannot move
  property p_quiet; (!wr_in && $stable(pins))[*4] |=> $stable(wake_req_out); endproperty
  a_quiet: assert property (p_quiet) else $error("quiet");
  property p_irqoff; wr_in && addr_in == 4'hc && !wdata_in[3:0] |=> ##1 !irq_out; endproperty
  a_irqoff: assert property (p_irqoff) else $error("irqoff");
  property p_hold; irq_out && !wr_in && !$past(wr_in) |=> irq_out; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  c_req: cover property (|wake_req_out);
  c_irq: cover property ($rose(irq_out));
  c_rd: cover property (rd_in && addr_in == 4'h0);
endmodule // swm_ctl_props
bind swm_ctl swm_ctl_props i_props (.*);

//--- sim/swm_pins.sv
/* Wake pin source; assumes calls between register cycles. */
`timescale 1ns/10ps
module swm_pins (
  // Clock
  input wire clk_in,
  // Pins, bit0 is line 4
  output reg [3:0] pins_out = 4'h0
);
  // Change just after an edge, as a synchronous source would
  task drive(input [3:0] v);
    @(posedge clk_in) pins_out <= v;
  endtask
endmodule // swm_pins

//--- sim/tb_swm_ctl.sv
/* Bench for swm_ctl; assumes swm_pins on the pins. */
`timescale 1ns/10ps
module tb_swm_ctl;
  reg clk_in = 1'b0;
  reg resetn_in = 1'b0;
  reg wr_in = 1'b0;
  reg rd_in = 1'b0;
  reg [3:0] addr_in = 4'h0;
  reg [3:0] wake_request_clear_in = 4'h0;
  reg [31:0] wdata_in = 32'h0;
  wire [31:0] rdata_out;
  wire [3:0] wake_req_out;
  wire [3:0] p;
  wire irq_out;
  integer miscompares = 0;
  integer check_count = 0;
  integer m;
  reg [7:0] w;
  // 50 MHz
  always #10 clk_in = ~clk_in;
  swm_pins i_pins (.clk_in(clk_in), .pins_out(p));
  swm_ctl i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .ext_wake_line4_in(p[0]), .ext_wake_line5_in(p[1]),
    .ext_wake_line6_in(p[2]), .ext_wake_line7_in(p[3]),
    .wake_request_clear_in(wake_request_clear_in),
    .wake_req_out(wake_req_out), .irq_out(irq_out));
  task ck(input string n, input [31:0] e, input [31:0] s);
    check_count = check_count + 1;
    if (s !== e) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  // One-cycle strobes
  task wr(input [3:0] a, input [31:0] d);
    @(posedge clk_in) {wr_in, addr_in, wdata_in} <= {1'b1, a, d};
    @(posedge clk_in) wr_in <= 1'b0;
  endtask
  task rd(input [3:0] a, input [31:0] e);
    @(posedge clk_in) {rd_in, addr_in} <= {1'b1, a};
    @(posedge clk_in) rd_in <= 1'b0;
    #1 ck("rdata", e, rdata_out);
  endtask
  task close_out;
    if (miscompares == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000 miscompares = miscompares + 1;
    close_out;
  end
  // Mode sweep, then status and interrupt
  initial begin
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(4'h0, 32'h20202020);
    for (m = 0; m < 5; m = m + 1) begin
      w = {1'b0, m[2:0], 4'h1};
      wr(4'h0, {4{w & 8'hfe}});
      #1 ck("req", 0, wake_req_out);
      wr(4'h0, {4{w}});
      repeat (3) @(posedge clk_in);
      #1 ck("req", m == 0 ? 4'hf : 0, wake_req_out);
      i_pins.drive(4'hf);
      repeat (2) @(posedge clk_in);
      #1 ck("req", 8'h1a >> m & 1 ? 4'hf : 0, wake_req_out);
      @(posedge clk_in);
      #1 ck("req", m == 1 ? 4'hf : 0, wake_req_out);
      rd(4'h0, {4{w | (m == 4 ? 8'h04 : 8'h00)}});
      if (m == 4) begin
        i_pins.drive(4'h0);
        repeat (3) @(posedge clk_in);
        rd(4'h0, {4{w | 8'h0c}});
        @(posedge clk_in) wake_request_clear_in <= 4'hf;
        @(posedge clk_in) wake_request_clear_in <= 4'h0;
        rd(4'h0, {4{w}});
      end
      // Disable first, then change the mode in a later write
      wr(4'h0, {4{w & 8'hfe}});
      wr(4'h0, 32'h0);
      i_pins.drive(4'h0);
      repeat (4) @(posedge clk_in);
    end
    #1 ck("irq", 0, irq_out);
    wr(4'hc, 32'hf);
    @(posedge clk_in);
    #1 ck("irq", 1, irq_out);
    rd(4'hc, 32'hf);
    wr(4'h4, 32'h0);
    rd(4'h4, 32'hf);
    wr(4'hc, 32'h0);
    @(posedge clk_in);
    #1 ck("irq", 0, irq_out);
    wr(4'hc, 32'hf);
    wr(4'h8, 32'hf);
    @(posedge clk_in);
    #1 ck("irq", 0, irq_out);
    rd(4'h4, 32'h0);
    rd(4'h8, 32'h0);
    close_out;
  end
endmodule // tb_swm_ctl
